// ===== core/timer_b_core.sv
// What this block does
// - Enable bit turns the counter on; while zero the counter stays idle.
// - Clock select: full clock, half clock, or companion timer clock.
// - Standby-run keeps counting in standby; ignored on companion clock.
// - Sync restart clears counter on companion restart; not on half clock.
// - Single-shot output rises at counter start, or at event when async.
// - Initial level bit sets pin level, except single-shot and 8-bit PWM.
// - Waveform enable makes the waveform override the port pin value.
// - Three-bit count mode field selects one of eight counting modes.
// - Noise filter bit routes the event input through the filter, except on the async single-shot output.
// - Event input enable gates all event-driven counter actions.
// - Periodic and 8-bit PWM modes ignore events and edges.
// - Time-out mode: selected edge starts, opposite edge stops counter.
// - Capture mode: selected edge copies count and raises flag.
// - Frequency mode: selected edge captures, clears, restarts, flags.
// - Pulse-width mode: selected edge restarts, opposite edge captures.
// - Combined mode: restart, capture on opposite, stop and flag on next.
// - Single-shot starts on rising edge, or on either edge if selected.
// - Filter passes a change only after four equal samples.
// - Flag clears on write of one, or capture read in capture modes.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module timer_b_core
    import timer_b_pkg::*;
(
    input  wire logic        CLK,          // Peripheral clock, 25 MHz
    input  wire logic        RST_N,        // Async reset, active low
    input  wire logic [3:0]  ADDR,         // Register byte address
    input  wire logic [7:0]  WDATA,        // Write data
    input  wire logic        WR,           // Write strobe
    input  wire logic        RD,           // Read strobe
    output logic      [7:0]  RDATA,        // Read data, cycle after RD
    input  wire logic        EVENT_IN,     // Event channel level
    input  wire logic        COMP_TICK,    // Companion timer clock tick
    input  wire logic        COMP_RESTART, // Companion restart/overflow
    input  wire logic        STANDBY,      // Standby sleep active
    input  wire logic        DEBUG_HALT,   // CPU halted in debug
    output logic             WAVE_OUT,     // Waveform level for the pin
    output logic             PIN_OVERRIDE, // Waveform owns the pin
    output logic             IRQ,          // Capture interrupt request
    output logic             RUNNING       // Counter running
);

    control_a_s     control_a_r;
    control_b_s     control_b_r;
    event_control_s event_control_r;
    logic           int_enable_r;
    logic           int_flag_r;
    logic           debug_run_r;
    logic [15:0]    cnt_r;
    logic [15:0]    capture_compare_value_r;
    logic           run_r;
    fp_phase_e      fp_r;
    fp_phase_e      fp_nxt;
    logic           sync1_r;
    logic           sync2_r;
    logic           raw_prev_r;
    logic [FILTER_SAMPLES-1:0] filt_hist_r;
    logic           filt_lvl_r;
    logic           ev_prev_r;
    logic           async_hi_r;
    logic           div_r;

    count_mode_e    mode;
    clock_select_e  clk_sel;
    logic           wr_a;
    logic           wr_b;
    logic           wr_ev;
    logic           wr_cnt;
    logic           wr_cc;
    logic           ev_lvl;
    logic           rise;
    logic           fall;
    logic           sel_edge;
    logic           opp_edge;
    logic           ev_on;
    logic           halted;
    logic           clk_tick;
    logic           tick;
    logic [15:0]    top;
    logic           top_hit;
    logic           start;
    logic           stop;
    logic           clear;
    logic           capture;
    logic           flag_ev;
    logic           sync_rst;
    logic           free_mode;
    logic           capture_interrupt_mode;
    logic           wave_lvl;

    assign mode    = count_mode_e'(control_b_r.count_mode);
    assign clk_sel = clock_select_e'(control_a_r.clock_select);
    assign wr_a    = WR && ADDR == ADR_CONTROL_A;
    assign wr_b    = WR && ADDR == ADR_CONTROL_B;
    assign wr_ev   = WR && ADDR == ADR_EVENT_CTRL;
    assign wr_cnt  = WR && (ADDR == ADR_CNT_LOW || ADDR == ADR_CNT_HIGH);
    assign wr_cc   = WR && (ADDR == ADR_CAPTURE_COMPARE_VALUE_LOW || ADDR == ADR_CAPTURE_COMPARE_VALUE_HIGH);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            control_a_r     <= control_a_s'(REG_RESET);
            control_b_r     <= control_b_s'(REG_RESET);
            event_control_r <= event_control_s'(REG_RESET);
            int_enable_r    <= 1'b0;
            debug_run_r     <= 1'b0;
        end else begin
            if (wr_a) begin
                control_a_r <= control_a_s'(WDATA & CONTROL_A_WMASK);
            end
            if (wr_b) begin
                control_b_r <= control_b_s'(WDATA & CONTROL_B_WMASK);
            end
            if (wr_ev) begin
                event_control_r <= event_control_s'(WDATA & EVENT_CTRL_WMASK);
            end
            if (WR && ADDR == ADR_INT_ENABLE) begin
                int_enable_r <= WDATA[0];
            end
            if (WR && ADDR == ADR_DEBUG_CTRL) begin
                debug_run_r <= WDATA[0];
            end
        end
    end

    // Event pin synchroniser; first stage feeds only the second
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_r    <= 1'b0;
            sync2_r    <= 1'b0;
            raw_prev_r <= 1'b0;
        end else begin
            sync1_r    <= EVENT_IN;
            sync2_r    <= sync1_r;
            raw_prev_r <= sync2_r;
        end
    end

    // four equal samples before the level moves
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            filt_hist_r <= '0;
            filt_lvl_r  <= 1'b0;
        end else begin
            filt_hist_r <= {filt_hist_r[FILTER_SAMPLES-2:0], sync2_r};
            if (&filt_hist_r) begin
                filt_lvl_r <= 1'b1;
            end else if (~|filt_hist_r) begin
                filt_lvl_r <= 1'b0;
            end
        end
    end

    assign ev_lvl = event_control_r.noise_filter ? filt_lvl_r : sync2_r;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ev_prev_r <= 1'b0;
        end else begin
            ev_prev_r <= ev_lvl;
        end
    end

    assign rise     = ev_lvl & ~ev_prev_r;
    assign fall     = ~ev_lvl & ev_prev_r;
    assign sel_edge = event_control_r.edge_select ? fall : rise;
    assign opp_edge = event_control_r.edge_select ? rise : fall;

    // standby gating, not applied on companion clock
    assign halted = (DEBUG_HALT && !debug_run_r)
                  || (STANDBY && !control_a_r.standby_run
                      && clk_sel != CLOCK_FROM_COMPANION
                      && clk_sel != CLOCK_FROM_COMP_ALT);
    assign ev_on = control_a_r.enable && !halted
                 && event_control_r.capture_event_input_enable;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_r <= 1'b0;
        end else begin
            div_r <= ~div_r;
        end
    end

    always_comb begin
        unique case (clk_sel)
            CLOCK_UNDIVIDED:      clk_tick = 1'b1;
            CLOCK_HALF:           clk_tick = div_r;
            CLOCK_FROM_COMP_ALT:  clk_tick = COMP_TICK;
            CLOCK_FROM_COMPANION: clk_tick = COMP_TICK;
        endcase
    end

    assign tick = control_a_r.enable && !halted && clk_tick;

    assign top = (mode == EIGHT_BIT_PULSE_MODE) ? {8'h00, capture_compare_value_r[7:0]}
                                                : capture_compare_value_r;
    assign top_hit = tick && run_r && cnt_r == top;
    assign sync_rst = control_a_r.enable && control_a_r.sync_restart
                    && COMP_RESTART && clk_sel != CLOCK_HALF;
    assign free_mode = mode == MODE_PERIODIC || mode == MODE_CAPTURE
                    || mode == FREQUENCY_MEASURE_MODE
                    || mode == PULSE_WIDTH_MODE
                    || mode == EIGHT_BIT_PULSE_MODE;
    assign capture_interrupt_mode = mode == MODE_CAPTURE
                    || mode == FREQUENCY_MEASURE_MODE
                    || mode == PULSE_WIDTH_MODE
                    || mode == FREQUENCY_AND_WIDTH_MODE;

    always_comb begin
        start   = 1'b0;
        stop    = 1'b0;
        clear   = 1'b0;
        capture = 1'b0;
        flag_ev = 1'b0;
        fp_nxt  = fp_r;
        if (ev_on) begin
            unique case (mode)
                MODE_TIMEOUT: begin
                    start = sel_edge;
                    stop  = opp_edge;
                end
                MODE_CAPTURE: begin
                    capture = sel_edge;
                    flag_ev = sel_edge;
                end
                FREQUENCY_MEASURE_MODE: begin
                    capture = sel_edge;
                    clear   = sel_edge;
                    flag_ev = sel_edge;
                end
                PULSE_WIDTH_MODE: begin
                    clear   = sel_edge;
                    capture = opp_edge;
                    flag_ev = opp_edge;
                end
                FREQUENCY_AND_WIDTH_MODE: begin
                    unique case (fp_r)
                        FP_IDLE: if (sel_edge) begin
                            clear  = 1'b1;
                            start  = 1'b1;
                            fp_nxt = FP_MEASURE;
                        end
                        FP_MEASURE: if (opp_edge) begin
                            capture = 1'b1;
                            fp_nxt  = FP_CAPTURED;
                        end
                        FP_CAPTURED: if (sel_edge) begin
                            stop    = 1'b1;
                            flag_ev = 1'b1;
                            fp_nxt  = FP_IDLE;
                        end
                        default: fp_nxt = FP_IDLE;
                    endcase
                end
                MODE_SINGLE_SHOT: begin
                    start = !run_r && (event_control_r.edge_select
                                       ? (rise || fall) : rise);
                end
                default: ;
            endcase
        end
        if (top_hit && (mode == MODE_PERIODIC || mode == MODE_TIMEOUT
                        || mode == MODE_SINGLE_SHOT
                        || mode == EIGHT_BIT_PULSE_MODE)) begin
            flag_ev = 1'b1;
        end
        if (top_hit && mode == MODE_SINGLE_SHOT) begin
            stop = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fp_r <= FP_IDLE;
        end else if (!control_a_r.enable
                     || mode != FREQUENCY_AND_WIDTH_MODE) begin
            fp_r <= FP_IDLE;
        end else begin
            fp_r <= fp_nxt;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            run_r <= 1'b0;
        end else if (!control_a_r.enable) begin
            run_r <= 1'b0;
        end else if (free_mode) begin
            run_r <= 1'b1;
        end else if (start) begin
            run_r <= 1'b1;
        end else if (stop) begin
            run_r <= 1'b0;
        end
    end

    // Software write beats every internal update
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_r <= WORD_RESET;
        end else if (WR && ADDR == ADR_CNT_LOW) begin
            cnt_r[7:0] <= WDATA;
        end else if (WR && ADDR == ADR_CNT_HIGH) begin
            cnt_r[15:8] <= WDATA;
        end else if (!control_a_r.enable) begin
            cnt_r <= cnt_r;
        end else if (clear || sync_rst || (top_hit && mode != MODE_CAPTURE
                     && mode != FREQUENCY_AND_WIDTH_MODE
                     && mode != PULSE_WIDTH_MODE
                     && mode != FREQUENCY_MEASURE_MODE)) begin
            cnt_r <= WORD_RESET;
        end else if (tick && run_r) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            capture_compare_value_r <= WORD_RESET;
        end else if (WR && ADDR == ADR_CAPTURE_COMPARE_VALUE_LOW) begin
            capture_compare_value_r[7:0] <= WDATA;
        end else if (WR && ADDR == ADR_CAPTURE_COMPARE_VALUE_HIGH) begin
            capture_compare_value_r[15:8] <= WDATA;
        end else if (capture) begin
            capture_compare_value_r <= cnt_r;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            int_flag_r <= 1'b0;
        end else if (flag_ev) begin
            int_flag_r <= 1'b1;
        end else if ((WR && ADDR == ADR_INT_FLAG && WDATA[0])
                     || (RD && ADDR == ADR_CAPTURE_COMPARE_VALUE_LOW && capture_interrupt_mode)) begin
            int_flag_r <= 1'b0;
        end
    end

    // async single-shot output, from the raw synchronised edge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            async_hi_r <= 1'b0;
        end else if (!control_a_r.enable || stop
                     || mode != MODE_SINGLE_SHOT) begin
            async_hi_r <= 1'b0;
        end else if (control_b_r.async_output && !run_r
                     && event_control_r.capture_event_input_enable
                     && (sync2_r != raw_prev_r)
                     && (event_control_r.edge_select || sync2_r)) begin
            async_hi_r <= 1'b1;
        end
    end

    // initial level outside single-shot and PWM
    always_comb begin
        unique case (mode)
            MODE_SINGLE_SHOT:     wave_lvl = run_r || async_hi_r;
            EIGHT_BIT_PULSE_MODE: wave_lvl = run_r
                                    && cnt_r[7:0] < capture_compare_value_r[15:8];
            default:              wave_lvl = control_b_r.output_initial_level;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            WAVE_OUT     <= 1'b0;
            PIN_OVERRIDE <= 1'b0;
            IRQ          <= 1'b0;
            RUNNING      <= 1'b0;
        end else begin
            WAVE_OUT     <= control_b_r.waveform_output_enable && wave_lvl;
            PIN_OVERRIDE <= control_b_r.waveform_output_enable;
            IRQ          <= int_flag_r && int_enable_r;
            RUNNING      <= run_r;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= REG_RESET;
        end else if (RD) begin
            unique case (ADDR)
                ADR_CONTROL_A:  RDATA <= control_a_r;
                ADR_CONTROL_B:  RDATA <= control_b_r;
                ADR_EVENT_CTRL: RDATA <= event_control_r;
                ADR_INT_ENABLE: RDATA <= {7'h00, int_enable_r};
                ADR_INT_FLAG:   RDATA <= {7'h00, int_flag_r};
                ADR_RUN_STATUS: RDATA <= {7'h00, run_r};
                ADR_DEBUG_CTRL: RDATA <= {7'h00, debug_run_r};
                ADR_CNT_LOW:    RDATA <= cnt_r[7:0];
                ADR_CNT_HIGH:   RDATA <= cnt_r[15:8];
                ADR_CAPTURE_COMPARE_VALUE_LOW:   RDATA <= capture_compare_value_r[7:0];
                ADR_CAPTURE_COMPARE_VALUE_HIGH:  RDATA <= capture_compare_value_r[15:8];
                default:        RDATA <= REG_RESET;
            endcase
        end else begin
            RDATA <= REG_RESET;
        end
    end

    a_disabled_holds: assert property (@(posedge CLK) disable iff (!RST_N)
        !control_a_r.enable && !wr_cnt |=> $stable(cnt_r))
        else $error("counter moved while disabled");
    a_half_clock_rate: assert property (@(posedge CLK) disable iff (!RST_N)
        tick && clk_sel == CLOCK_HALF && !wr_a |=> !tick)
        else $error("half clock ticked twice in a row");
    a_sync_restart: assert property (@(posedge CLK) disable iff (!RST_N)
        sync_rst && !wr_cnt |=> cnt_r == WORD_RESET)
        else $error("sync restart did not clear counter");
    a_wave_off: assert property (@(posedge CLK) disable iff (!RST_N)
        !control_b_r.waveform_output_enable |=> !WAVE_OUT && !PIN_OVERRIDE)
        else $error("waveform drove pin while disabled");
    a_event_gate: assert property (@(posedge CLK) disable iff (!RST_N)
        !ev_on |-> !(capture || clear || (start && !free_mode)))
        else $error("event acted while gated");
    a_mode_ignores: assert property (@(posedge CLK) disable iff (!RST_N)
        mode == MODE_PERIODIC || mode == EIGHT_BIT_PULSE_MODE
        |-> !(capture || clear || start))
        else $error("event acted in periodic or PWM mode");
    a_timeout_start: assert property (@(posedge CLK) disable iff (!RST_N)
        ev_on && mode == MODE_TIMEOUT && sel_edge && !wr_a |=> run_r)
        else $error("timeout edge did not start counter");
    a_freq_capture: assert property (@(posedge CLK) disable iff (!RST_N)
        ev_on && mode == FREQUENCY_MEASURE_MODE && sel_edge && !wr_cc
        |=> capture_compare_value_r == $past(cnt_r) && int_flag_r)
        else $error("frequency capture wrong");
    a_filter_stable: assert property (@(posedge CLK) disable iff (!RST_N)
        $changed(filt_lvl_r)
        |-> $past(filt_hist_r) == {FILTER_SAMPLES{filt_lvl_r}})
        else $error("filter passed an unstable level");
    a_flag_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        WR && ADDR == ADR_INT_FLAG && WDATA[0] && !flag_ev |=> !int_flag_r)
        else $error("flag not cleared by write of one");
    a_read_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        RD && ADDR == ADR_CAPTURE_COMPARE_VALUE_LOW && capture_interrupt_mode && !flag_ev |=> !int_flag_r)
        else $error("flag not cleared by capture read");

    c_single_shot: cover property (@(posedge CLK) disable iff (!RST_N)
        mode == MODE_SINGLE_SHOT && start ##[1:50] stop);
    c_fp_done: cover property (@(posedge CLK) disable iff (!RST_N)
        fp_r == FP_CAPTURED && fp_nxt == FP_IDLE);
    c_pwm_wave: cover property (@(posedge CLK) disable iff (!RST_N)
        mode == EIGHT_BIT_PULSE_MODE && WAVE_OUT ##1 !WAVE_OUT);

endmodule : timer_b_core

`default_nettype wire

// ===== core/timer_b_pkg.sv
package timer_b_pkg;

    // Register byte addresses
    localparam logic [3:0] ADR_CONTROL_A  = 4'h0;
    localparam logic [3:0] ADR_CONTROL_B  = 4'h1;
    localparam logic [3:0] ADR_EVENT_CTRL = 4'h4;
    localparam logic [3:0] ADR_INT_ENABLE = 4'h5;
    localparam logic [3:0] ADR_INT_FLAG   = 4'h6;
    localparam logic [3:0] ADR_RUN_STATUS = 4'h7;
    localparam logic [3:0] ADR_DEBUG_CTRL = 4'h8;
    localparam logic [3:0] ADR_CNT_LOW    = 4'hA;
    localparam logic [3:0] ADR_CNT_HIGH   = 4'hB;
    localparam logic [3:0] ADR_CAPTURE_COMPARE_VALUE_LOW   = 4'hC;
    localparam logic [3:0] ADR_CAPTURE_COMPARE_VALUE_HIGH  = 4'hD;

    // Writable bits of each register, all others read zero
    localparam logic [7:0] CONTROL_A_WMASK  = 8'h57;
    localparam logic [7:0] CONTROL_B_WMASK  = 8'h77;
    localparam logic [7:0] EVENT_CTRL_WMASK = 8'h51;
    localparam logic [7:0] BIT0_WMASK       = 8'h01;
    localparam logic [7:0] REG_RESET        = 8'h00;
    localparam logic [15:0] WORD_RESET      = 16'h0000;

    localparam int FILTER_SAMPLES = 4;

    typedef enum logic [1:0] {
        CLOCK_UNDIVIDED     = 2'b00,
        CLOCK_HALF          = 2'b01,
        CLOCK_FROM_COMP_ALT = 2'b10,
        CLOCK_FROM_COMPANION = 2'b11
    } clock_select_e;

    typedef enum logic [2:0] {
        MODE_PERIODIC          = 3'b000,
        MODE_TIMEOUT           = 3'b001,
        MODE_CAPTURE           = 3'b010,
        FREQUENCY_MEASURE_MODE = 3'b011,
        PULSE_WIDTH_MODE       = 3'b100,
        FREQUENCY_AND_WIDTH_MODE = 3'b101,
        MODE_SINGLE_SHOT       = 3'b110,
        EIGHT_BIT_PULSE_MODE   = 3'b111
    } count_mode_e;

    typedef enum logic [1:0] {
        FP_IDLE     = 2'b00,
        FP_MEASURE  = 2'b01,
        FP_CAPTURED = 2'b10
    } fp_phase_e;

    typedef struct packed {
        logic       rsv7;
        logic       standby_run;
        logic       rsv5;
        logic       sync_restart;
        logic       rsv3;
        logic [1:0] clock_select;
        logic       enable;
    } control_a_s;

    typedef struct packed {
        logic       rsv7;
        logic       async_output;
        logic       output_initial_level;
        logic       waveform_output_enable;
        logic       rsv3;
        logic [2:0] count_mode;
    } control_b_s;

    typedef struct packed {
        logic       rsv7;
        logic       noise_filter;
        logic       rsv5;
        logic       edge_select;
        logic [2:0] rsv3_1;
        logic       capture_event_input_enable;
    } event_control_s;

endpackage : timer_b_pkg

// ===== tb/event_partner.sv
`timescale 1ns/100ps
`default_nettype none

module event_partner (
    input  wire logic CLK,          // Peripheral clock
    input  wire logic LEVEL,        // Wanted event level
    input  wire logic RESTART,      // Wanted restart pulse
    output var logic  EVENT_IN,     // Event channel level
    output var logic  COMP_TICK,    // Companion clock tick
    output var logic  COMP_RESTART  // Companion restart pulse
);
    initial begin
        EVENT_IN = 1'b0;
        COMP_TICK = 1'b0;
        COMP_RESTART = 1'b0;
    end
    always @(posedge CLK) EVENT_IN <= LEVEL;
    // Companion ticks at half rate
    always @(posedge CLK) COMP_TICK <= ~COMP_TICK;
    always @(posedge CLK) COMP_RESTART <= RESTART;
endmodule : event_partner

`default_nettype wire

// ===== tb/timer_b_mode_and_event_control_bench.sv
`timescale 1ns/100ps
`default_nettype none

module timer_b_mode_and_event_control_bench;
    import timer_b_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr_s = 1'b0;
    logic       rd_s = 1'b0;
    logic       lvl = 1'b0;
    logic       stby = 1'b0;
    logic       rq = 1'b0;
    logic [7:0] rdata;
    logic       ev, tick, rst_c, wave, ovr, irq, run;
    int         mismatches = 0;
    int         comparisons = 0;

    always #20 clk = ~clk;

    event_partner u_event_partner (.CLK(clk), .LEVEL(lvl), .RESTART(rq),
        .EVENT_IN(ev), .COMP_TICK(tick), .COMP_RESTART(rst_c));
    timer_b_core u_timer_b_core (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .EVENT_IN(ev),
        .COMP_TICK(tick), .COMP_RESTART(rst_c), .STANDBY(stby),
        .DEBUG_HALT(1'b0), .WAVE_OUT(wave), .PIN_OVERRIDE(ovr),
        .IRQ(irq), .RUNNING(run));

    task chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd

    // Bounded wait on output k of {wave, run, irq}
    task await(input int k, input logic v);
        logic [2:0] o;
        o = 3'h0;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            #1;
            o = {wave, run, irq};
            if (o[k] === v) break;
        end
        chk({7'h00, o[k]}, {7'h00, v});
        if (o[k] !== v) end_of_test();
    endtask : await

    // Event path is 3 clocks plus the flag register
    task drive(input logic v);
        @(posedge clk);
        lvl <= v;
        repeat (12) @(posedge clk);
        #1;
    endtask : drive

    task t_regs;
        rd(ADR_CONTROL_A, 8'h00);
        wr(ADR_CONTROL_A, 8'hFF);
        rd(ADR_CONTROL_A, 8'h57);
        wr(ADR_CONTROL_A, 8'h00);
        wr(ADR_CONTROL_B, 8'hFF);
        rd(ADR_CONTROL_B, 8'h77);
        wr(ADR_EVENT_CTRL, 8'hFF);
        rd(ADR_EVENT_CTRL, 8'h51);
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'h00);
        wr(ADR_CONTROL_B, 8'h00);
        wr(ADR_EVENT_CTRL, 8'h00);
        wr(ADR_CONTROL_A, 8'h03);
        await(1, 1'b1);
        wr(ADR_CONTROL_A, 8'h00);
        await(1, 1'b0);
        $display("registers done");
    endtask : t_regs

    task t_edge(input logic [2:0] m, input logic e);
        wr(ADR_CONTROL_B, {5'h00, m});
        wr(ADR_EVENT_CTRL, {3'h0, e, 4'h0});
        wr(ADR_INT_ENABLE, 8'h01);
        wr(ADR_CONTROL_A, 8'h01);
        drive(e);
        wr(ADR_INT_FLAG, 8'h01);
        drive(~e);
        chk({7'h00, irq}, 8'h00);
        drive(e);
        wr(ADR_EVENT_CTRL, {3'h0, e, 4'h1});
        drive(~e);
        chk({7'h00, irq}, 8'h01);
        rd(ADR_INT_FLAG, 8'h01);
        wr(ADR_INT_FLAG, 8'h01);
        await(0, 1'b0);
        drive(e);
        chk({7'h00, irq}, 8'h00);
        wr(ADR_CONTROL_A, 8'h00);
        $display("edge mode %0d done", m);
    endtask : t_edge

    task t_tout(input logic e);
        wr(ADR_CONTROL_B, 8'h01);
        wr(ADR_CAPTURE_COMPARE_VALUE_HIGH, 8'hFF);
        wr(ADR_EVENT_CTRL, {3'h2, e, 4'h1});
        wr(ADR_CONTROL_A, 8'h01);
        drive(e);
        drive(~e);
        await(1, 1'b1);
        // Two-cycle glitch must not pass the filter
        @(posedge clk);
        lvl <= e;
        repeat (2) @(posedge clk);
        lvl <= ~e;
        drive(~e);
        await(1, 1'b1);
        drive(e);
        await(1, 1'b0);
        wr(ADR_CONTROL_A, 8'h00);
        $display("time-out done");
    endtask : t_tout

    task t_wave;
        wr(ADR_CONTROL_B, 8'h30);
        await(2, 1'b1);
        chk({7'h00, ovr}, 8'h01);
        wr(ADR_CONTROL_B, 8'h37);
        await(2, 1'b0);
        wr(ADR_CONTROL_B, 8'h20);
        await(2, 1'b0);
        chk({7'h00, ovr}, 8'h00);
        $display("waveform done");
    endtask : t_wave

    task t_sync;
        wr(ADR_CONTROL_B, 8'h00);
        wr(ADR_CONTROL_A, 8'h11);
        @(posedge clk);
        rq <= 1'b1;
        @(posedge clk);
        rq <= 1'b0;
        wr(ADR_CONTROL_A, 8'h00);
        rd(ADR_CNT_LOW, 8'h01);
        @(posedge clk);
        stby <= 1'b1;
        wr(ADR_CONTROL_A, 8'h01);
        wr(ADR_CONTROL_A, 8'h00);
        rd(ADR_CNT_LOW, 8'h01);
        wr(ADR_CONTROL_A, 8'h41);
        wr(ADR_CONTROL_A, 8'h00);
        rd(ADR_CNT_LOW, 8'h02);
        @(posedge clk);
        stby <= 1'b0;
        $display("sync and standby done");
    endtask : t_sync

    task t_shot;
        wr(ADR_CAPTURE_COMPARE_VALUE_HIGH, 8'h00);
        wr(ADR_CAPTURE_COMPARE_VALUE_LOW, 8'h08);
        wr(ADR_CNT_HIGH, 8'h00);
        wr(ADR_CNT_LOW, 8'h00);
        wr(ADR_CONTROL_B, 8'h36);
        wr(ADR_EVENT_CTRL, 8'h01);
        drive(1'b0);
        wr(ADR_CONTROL_A, 8'h01);
        await(2, 1'b0);
        @(posedge clk);
        lvl <= 1'b1;
        await(2, 1'b1);
        await(2, 1'b0);
        wr(ADR_CONTROL_A, 8'h00);
        $display("single-shot done");
    endtask : t_shot

    task t_pw;
        wr(ADR_CONTROL_B, 8'h04);
        wr(ADR_EVENT_CTRL, 8'h01);
        drive(1'b0);
        wr(ADR_CONTROL_A, 8'h01);
        wr(ADR_INT_FLAG, 8'h01);
        drive(1'b1);
        chk({7'h00, irq}, 8'h00);
        drive(1'b0);
        chk({7'h00, irq}, 8'h01);
        rd(ADR_CAPTURE_COMPARE_VALUE_LOW, 8'h0C);
        rd(ADR_INT_FLAG, 8'h00);
        wr(ADR_CONTROL_A, 8'h00);
        $display("pulse width done");
    endtask : t_pw

    task end_of_test;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_edge(3'h2, 1'b0);
        t_edge(3'h3, 1'b1);
        t_tout(1'b0);
        t_tout(1'b1);
        t_sync();
        t_shot();
        t_pw();
        t_wave();
        end_of_test();
    end
endmodule : timer_b_mode_and_event_control_bench

`default_nettype wire
